// File: include/aol_pkg.sv
// Functional notes
// RULE1 - run indicator on output two: moving=1
// RULE2 - no step edge 20 us around indicator change
// RULE3 - indicator selected: data bit two not driven
// RULE4 - watchdog zero: output three plain output
// RULE5 - watchdog nonzero: high, low after stop time
// RULE6 - motion during count restarts the watchdog
// RULE7 - zero write to output three blocked moving
// RULE8 - watchdog 0..255, 2.55 s per count
// RULE9 - start refused with error if output three low
// RULE10 - reset: watchdog zero, start condition off
// RULE11 - reset: run indicator option off
// RULE12 - four separate pin inversion settings
// RULE13 - reset: all inversions off
// RULE14 - link arrived after three consecutive formed scans
// RULE15 - link loss after 0.5 s not arrived
// RULE16 - link loss pin high while lost
// RULE17 - loss in motion stops axis if enabled; code leaves a manual move running (no stop_req)
// RULE18 - top speed phase loss stop is immediate
// RULE19 - loss entry clears data bits zero to two
// RULE20 - no new manual move during link loss
// RULE21 - reset: loss stop on, decel, no clear
// RULE22 - regained link restarts timer, clears loss
// RULE23 - free prescaler makes 2.55 s watchdog tick
package aol_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int CYC_PER_MS    = 1_000_000 / CLK_PERIOD_NS;

  localparam int STEP_GUARD_NS  = 20_000;
  localparam int STEP_GUARD_CYC =
    (STEP_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDOG_TICK_MS   = 2550;
  localparam int WDOG_TICK_CYC  = WDOG_TICK_MS * CYC_PER_MS;
  localparam int LINK_LOSS_MS   = 500;
  localparam int LINK_LOSS_CYC  = LINK_LOSS_MS * CYC_PER_MS;
  localparam int LINK_SCANS     = 3;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WDOG   = 8'h04;
  localparam logic [7:0] ADDR_OUTS   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // status bit positions
  localparam int ST_START_REFUSED = 0;
  localparam int ST_LOSS_EVENT    = 1;
  localparam int ST_MOVING        = 8;
  localparam int ST_ARRIVED       = 9;
  localparam int ST_LOST          = 10;
  localparam int ST_PINS          = 12;

  typedef struct packed {
    logic clear_low_outputs_on_link_loss; // bit 8
    logic stop_type_select;               // bit 7, 1 = immediate
    logic stop_on_link_loss;              // bit 6
    logic invert_encoder_count_direction; // bit 5
    logic invert_rotation_direction;      // bit 4
    logic invert_out_three;               // bit 3
    logic invert_low_outputs;             // bit 2
    logic start_needs_out_three_high;     // bit 1
    logic out_two_function_select;        // bit 0
  } aol_ctrl_t;

  localparam aol_ctrl_t CTRL_RESET = 9'h040;
  localparam logic [7:0] WDOG_RESET = 8'h00;
  localparam logic [3:0] OUTS_RESET = 4'h0;

  typedef struct packed {
    logic axis_moving;
    logic distance_move_top_speed_phase;
    logic target_move_top_speed_phase;
    logic manual_active;
  } aol_motion_t;

endpackage

// File: rtl/aol_supervisor.sv
`timescale 1ns/1ps
module aol_supervisor #(
  parameter int GUARD_CYC = aol_pkg::STEP_GUARD_CYC,
  parameter int TICK_CYC  = aol_pkg::WDOG_TICK_CYC,
  parameter int LOSS_CYC  = aol_pkg::LINK_LOSS_CYC
) (
  input  wire logic               sys_clk,        // 250 MHz
  input  wire logic               sys_rst,        // sync, active high
  input  wire logic               hsel,           // ahb select
  input  wire logic [31:0]        haddr,          // ahb address
  input  wire logic [1:0]         htrans,         // ahb transfer type
  input  wire logic               hwrite,         // ahb write
  input  wire logic [2:0]         hsize,          // ahb size
  input  wire logic [31:0]        hwdata,         // ahb write data
  input  wire logic               hready,         // ahb bus ready
  output logic [31:0]             hrdata,         // ahb read data
  output logic                    hreadyout,      // ahb slave ready
  output logic                    hresp,          // always okay
  input  wire aol_pkg::aol_motion_t motion,       // axis state
  input  wire logic               start_req,      // start instr pulse
  input  wire logic               manual_req,     // manual start pulse
  input  wire logic               step_in,        // raw step pulse
  input  wire logic               dir_in,         // raw direction
  input  wire logic               scan_done,      // scan end pulse
  input  wire logic               link_formed,    // link this scan
  input  wire logic               encoder_up_down_pin, // async pin
  output logic                    start_grant,    // start accepted
  output logic                    start_error,    // start refused
  output logic                    manual_grant,   // manual accepted
  output logic                    stop_req,       // stop axis pulse
  output logic                    stop_immediate, // with stop_req
  output logic                    step_out,       // step pin
  output logic                    dir_out,        // direction pin
  output logic                    count_up,       // encoder direction
  output logic [3:0]              general_out,    // general out pins
  output logic                    peer_link_lost  // link loss pin
);

  aol_pkg::aol_ctrl_t ctrl_reg;
  logic [7:0]         wdog_reg;
  logic [3:0]         outs_reg;
  logic [1:0]         sticky_reg;

  logic               ph_valid_reg;
  logic               ph_write_reg;
  logic [7:0]         ph_addr_reg;
  logic               rd_pend_reg;

  logic               run_ind_reg;
  logic [15:0]        guard_cnt_reg;
  logic               step_hold_reg;

  logic [31:0]        pre_cnt_reg;
  logic               wd_tick;
  logic [7:0]         wd_ticks_reg;
  logic               wd_expire;

  logic [1:0]         scan_cnt_reg;
  logic               arrived;
  logic [31:0]        loss_cnt_reg;
  logic               lost_reg;
  logic               lost_enter;

  logic               enc_s1_reg;
  logic               enc_s2_reg;

  logic               wr_en;
  logic               wdog_on;
  logic               out3_level;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign wr_en     = ph_valid_reg && ph_write_reg;
  assign wdog_on   = (wdog_reg != 8'h00);
  assign out3_level = outs_reg[3];

  // ---------------- ahb-lite slave ----------------
  // reads take one wait state so a write just before is seen
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
    end else if (hready) begin
      ph_valid_reg <= hsel && htrans[1];
      ph_write_reg <= hwrite;
      ph_addr_reg  <= {haddr[7:2], 2'b00};
    end else begin
      ph_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_pend_reg <= 1'b0;
      hreadyout   <= 1'b1;
      hrdata      <= 32'h0000_0000;
      hresp       <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        rd_pend_reg <= 1'b1;
        hreadyout   <= 1'b0;
      end else begin
        rd_pend_reg <= 1'b0;
        hreadyout   <= 1'b1;
      end
      if (rd_pend_reg) begin
        if (hit(ph_addr_reg, aol_pkg::ADDR_CTRL)) begin
          hrdata <= {23'h00_0000, ctrl_reg};
        end else if (hit(ph_addr_reg, aol_pkg::ADDR_WDOG)) begin
          hrdata <= {24'h00_0000, wdog_reg};
        end else if (hit(ph_addr_reg, aol_pkg::ADDR_OUTS)) begin
          hrdata <= {28'h000_0000, outs_reg};
        end else if (hit(ph_addr_reg, aol_pkg::ADDR_STATUS)) begin
          hrdata <= 32'h0000_0000;
          hrdata[1:0] <= sticky_reg;
          hrdata[aol_pkg::ST_MOVING]  <= motion.axis_moving;
          hrdata[aol_pkg::ST_ARRIVED] <= arrived;
          hrdata[aol_pkg::ST_LOST]    <= lost_reg;
          hrdata[aol_pkg::ST_PINS +: 4] <= general_out;
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ---------------- configuration ----------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg <= aol_pkg::CTRL_RESET; // RULE10 RULE11 RULE13 RULE21
      wdog_reg <= aol_pkg::WDOG_RESET; // RULE10
    end else if (wr_en) begin
      if (hit(ph_addr_reg, aol_pkg::ADDR_CTRL)) begin
        ctrl_reg <= hwdata[8:0]; // RULE12
      end
      if (hit(ph_addr_reg, aol_pkg::ADDR_WDOG)) begin
        wdog_reg <= hwdata[7:0]; // RULE8
      end
    end
  end

  // event flags, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sticky_reg <= 2'b00;
    end else begin
      if (wr_en && hit(ph_addr_reg, aol_pkg::ADDR_STATUS)) begin
        sticky_reg <= sticky_reg & ~hwdata[1:0];
      end
      if (start_req && ctrl_reg.start_needs_out_three_high && !out3_level) begin
        sticky_reg[aol_pkg::ST_START_REFUSED] <= 1'b1;
      end
      if (lost_enter) begin
        sticky_reg[aol_pkg::ST_LOSS_EVENT] <= 1'b1;
      end
    end
  end

  // ---------------- output data and watchdog ----------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pre_cnt_reg <= 32'h0000_0000;
    end else if (pre_cnt_reg >= 32'(TICK_CYC - 1)) begin
      pre_cnt_reg <= 32'h0000_0000; // RULE23
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 32'h0000_0001;
    end
  end

  assign wd_tick   = (pre_cnt_reg >= 32'(TICK_CYC - 1));
  assign wd_expire = wdog_on && !motion.axis_moving && wd_tick &&
                     (wd_ticks_reg + 8'h01 >= wdog_reg); // RULE5

  // stopped-time count, restarted by any motion
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wd_ticks_reg <= 8'h00;
    end else if (!wdog_on || motion.axis_moving) begin
      wd_ticks_reg <= 8'h00; // RULE6
    end else if (wd_tick && wd_ticks_reg != 8'hFF) begin
      wd_ticks_reg <= wd_ticks_reg + 8'h01; // RULE23
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      outs_reg <= aol_pkg::OUTS_RESET;
    end else begin
      if (wr_en && hit(ph_addr_reg, aol_pkg::ADDR_OUTS)) begin
        outs_reg[2:0] <= hwdata[2:0];
        if (!(wdog_on && motion.axis_moving && !hwdata[3])) begin
          outs_reg[3] <= hwdata[3]; // RULE4 RULE7
        end
      end
      if (lost_enter && ctrl_reg.clear_low_outputs_on_link_loss) begin
        outs_reg[2:0] <= 3'b000; // RULE19
      end
      // enabling or moving drives high; the expiry drives low
      if (wr_en && hit(ph_addr_reg, aol_pkg::ADDR_WDOG) &&
          hwdata[7:0] != 8'h00) begin
        outs_reg[3] <= 1'b1; // RULE5
      end else if (wdog_on && motion.axis_moving) begin
        outs_reg[3] <= 1'b1; // RULE5
      end else if (wd_expire) begin
        outs_reg[3] <= 1'b0; // RULE5
      end
    end
  end

  // ---------------- run indicator and step guard ----------------
  // the indicator change is delayed by one guard so that the step
  // line is frozen both before and after the edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      guard_cnt_reg <= 16'h0000;
      run_ind_reg   <= 1'b0;
    end else if (guard_cnt_reg != 16'h0000) begin
      guard_cnt_reg <= guard_cnt_reg - 16'h0001;
      if (guard_cnt_reg == 16'(GUARD_CYC + 1)) begin
        run_ind_reg <= motion.axis_moving; // RULE1
      end
    end else if (ctrl_reg.out_two_function_select &&
                 motion.axis_moving != run_ind_reg) begin
      guard_cnt_reg <= 16'(2 * GUARD_CYC + 1); // RULE2
    end else if (!ctrl_reg.out_two_function_select) begin
      run_ind_reg <= motion.axis_moving;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      step_hold_reg <= 1'b0;
      step_out      <= 1'b0;
    end else if (guard_cnt_reg != 16'h0000) begin
      step_out <= step_hold_reg; // RULE2
    end else begin
      step_hold_reg <= step_in;
      step_out      <= step_in;
    end
  end

  // ---------------- pins ----------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      enc_s1_reg <= 1'b0;
      enc_s2_reg <= 1'b0;
    end else begin
      enc_s1_reg <= encoder_up_down_pin;
      enc_s2_reg <= enc_s1_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      general_out <= 4'h0;
      dir_out     <= 1'b0;
      count_up    <= 1'b0;
    end else begin
      general_out[1:0] <= outs_reg[1:0] ^ {2{ctrl_reg.invert_low_outputs}};
      general_out[2]   <= (ctrl_reg.out_two_function_select ?
                           run_ind_reg : outs_reg[2]) ^
                          ctrl_reg.invert_low_outputs; // RULE1 RULE3 RULE12
      general_out[3]   <= outs_reg[3] ^ ctrl_reg.invert_out_three; // RULE12
      dir_out  <= dir_in ^ ctrl_reg.invert_rotation_direction; // RULE12
      count_up <= enc_s2_reg ^
                  ctrl_reg.invert_encoder_count_direction; // RULE12
    end
  end

  // ---------------- start gating ----------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      start_grant  <= 1'b0;
      start_error  <= 1'b0;
      manual_grant <= 1'b0;
    end else begin
      start_error  <= start_req && ctrl_reg.start_needs_out_three_high &&
                      !out3_level; // RULE9
      start_grant  <= start_req && !(ctrl_reg.start_needs_out_three_high &&
                      !out3_level); // RULE9
      manual_grant <= manual_req && !lost_reg; // RULE20
    end
  end

  // ---------------- link supervision ----------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scan_cnt_reg <= 2'b00;
    end else if (scan_done) begin
      if (!link_formed) begin
        scan_cnt_reg <= 2'b00;
      end else if (scan_cnt_reg != 2'(aol_pkg::LINK_SCANS)) begin
        scan_cnt_reg <= scan_cnt_reg + 2'b01; // RULE14
      end
    end
  end

  assign arrived = (scan_cnt_reg == 2'(aol_pkg::LINK_SCANS)); // RULE14

  assign lost_enter = !lost_reg && !arrived &&
                      (loss_cnt_reg >= 32'(LOSS_CYC - 1)); // RULE15

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      loss_cnt_reg <= 32'h0000_0000;
      lost_reg     <= 1'b0;
    end else if (arrived) begin
      loss_cnt_reg <= 32'h0000_0000; // RULE22
      lost_reg     <= 1'b0; // RULE22
    end else if (lost_enter) begin
      lost_reg <= 1'b1; // RULE15
    end else if (!lost_reg) begin
      loss_cnt_reg <= loss_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      peer_link_lost <= 1'b0;
      stop_req       <= 1'b0;
      stop_immediate <= 1'b0;
    end else begin
      peer_link_lost <= lost_reg || lost_enter; // RULE16
      // a manual move in progress is left to finish
      stop_req <= lost_enter && ctrl_reg.stop_on_link_loss &&
                  motion.axis_moving && !motion.manual_active; // RULE17 RULE20
      stop_immediate <= lost_enter && ctrl_reg.stop_on_link_loss &&
                        motion.axis_moving && !motion.manual_active &&
                        (ctrl_reg.stop_type_select ||
                         motion.distance_move_top_speed_phase ||
                         motion.target_move_top_speed_phase); // RULE18
    end
  end

endmodule

// File: verification/aol_supervisor_properties.sv
`timescale 1ns/1ps
module aol_checker #(
  parameter int GUARD_CYC = 4,
  parameter int LOSS_CYC  = 30
) (
  input wire logic                 sys_clk,        // clock
  input wire logic                 sys_rst,        // sync reset
  input wire aol_pkg::aol_motion_t motion,         // axis state
  input wire logic                 start_req,      // start pulse
  input wire logic                 start_grant,    // start accepted
  input wire logic                 start_error,    // start refused
  input wire logic                 manual_req,     // manual pulse
  input wire logic                 manual_grant,   // manual accepted
  input wire logic                 stop_req,       // stop pulse
  input wire logic                 stop_immediate, // stop kind
  input wire logic                 step_out,       // step pin
  input wire logic [3:0]           general_out,    // output pins
  input wire logic                 peer_link_lost, // loss pin
  input wire logic                 scan_done,      // scan end
  input wire logic                 link_formed     // link this scan
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] since_mv;
  logic [15:0] since_st;
  logic [31:0] since_fm;
  logic [1:0]  fcnt;
  // saturating ages so long idle stretches never wrap into a window
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      since_mv <= 16'hffff;
      since_st <= 16'hffff;
    end else begin
      since_mv <= $changed(motion.axis_moving) ? 16'h0000 :
                  since_mv + {15'h0000, since_mv != 16'hffff};
      since_st <= $changed(step_out) ? 16'h0000 :
                  since_st + {15'h0000, since_st != 16'hffff};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      since_fm <= 32'h0000_0000;
      fcnt     <= 2'h0;
    end else begin
      since_fm <= (scan_done && link_formed) ? 32'h0000_0000 : since_fm + 1;
      if (scan_done)
        fcnt <= !link_formed ? 2'h0 : fcnt + {1'b0, fcnt != 2'h3};
    end
  end
  property p_start_ans; start_req |=> start_grant != start_error; endproperty
  a_start_ans: assert property (p_start_ans)
    else $error("start answer not exactly one of grant or error");
  property p_start_why;
    start_grant || start_error |-> $past(start_req);
  endproperty
  a_start_why: assert property (p_start_why)
    else $error("start answer without request");
  property p_loss_wait; $rose(peer_link_lost) |-> since_fm >= LOSS_CYC;
  endproperty
  a_loss_wait: assert property (p_loss_wait)
    else $error("link loss declared too early");
  property p_loss_clear;
    fcnt == 2'h3 && peer_link_lost |-> ##[1:3] !peer_link_lost;
  endproperty
  a_loss_clear: assert property (p_loss_clear)
    else $error("link loss kept after link arrived");
  property p_manual_block;
    manual_req && peer_link_lost && fcnt != 2'h3 |=> !manual_grant;
  endproperty
  a_manual_block: assert property (p_manual_block)
    else $error("manual move granted during link loss");
  property p_stop_entry; stop_req |-> $rose(peer_link_lost); endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop issued outside link loss entry");
  property p_stop_fast;
    stop_req && ($past(motion.distance_move_top_speed_phase) ||
                 $past(motion.target_move_top_speed_phase)) |-> stop_immediate;
  endproperty
  a_stop_fast: assert property (p_stop_fast)
    else $error("top speed loss stop not immediate");
  property p_guard_after;
    $changed(step_out) |-> !(since_mv inside {[2:2*GUARD_CYC]});
  endproperty
  a_guard_after: assert property (p_guard_after)
    else $error("step edge inside guard window");
  property p_guard_before;
    $changed(general_out[2]) && since_mv < 16 |-> since_st >= GUARD_CYC - 1;
  endproperty
  a_guard_before: assert property (p_guard_before)
    else $error("step edge just before indicator change");
endmodule

bind aol_supervisor aol_checker #(
  .GUARD_CYC(GUARD_CYC),
  .LOSS_CYC (LOSS_CYC)
) i_aol_checker (
  .sys_clk       (sys_clk),
  .sys_rst       (sys_rst),
  .motion        (motion),
  .start_req     (start_req),
  .start_grant   (start_grant),
  .start_error   (start_error),
  .manual_req    (manual_req),
  .manual_grant  (manual_grant),
  .stop_req      (stop_req),
  .stop_immediate(stop_immediate),
  .step_out      (step_out),
  .general_out   (general_out),
  .peer_link_lost(peer_link_lost),
  .scan_done     (scan_done),
  .link_formed   (link_formed)
);

// File: verification/aol_link_peer.sv
`timescale 1ns/1ps
module aol_link_peer #(
  parameter int SCAN_CYC = 4
) (
  input  wire logic sys_clk,     // clock
  input  wire logic sys_rst,     // sync reset
  input  wire logic link_up,     // peer reachable
  output logic      scan_done,   // scan end pulse
  output logic      link_formed  // valid with scan_done only
);
  int cnt;
  // between scans the formed line carries no meaning, so it is scrambled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt         <= 0;
      scan_done   <= 1'b0;
      link_formed <= 1'b0;
    end else begin
      cnt         <= (cnt == SCAN_CYC - 1) ? 0 : cnt + 1;
      scan_done   <= (cnt == SCAN_CYC - 1);
      link_formed <= (cnt == SCAN_CYC - 1) ? link_up : ~link_formed;
    end
  end
endmodule

// File: verification/tb_axis_aux_output_link_supervisor.sv
`timescale 1ns/1ps
module tb_axis_aux_output_link_supervisor;
  localparam int G = 4;
  localparam int TICK = 20;
  localparam int LOSS = 30;
  logic sys_clk, sys_rst, hsel, hwrite, start_req, manual_req, step_in, dir_in;
  logic enc_pin, link_up, hreadyout, hresp, start_grant, start_error, tog;
  logic manual_grant, stop_req, stop_immediate, step_out, dir_out, count_up;
  logic peer_link_lost, scan_done, link_formed, imm_q;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans;
  logic [3:0]  general_out;
  logic [8:0]  c;
  aol_pkg::aol_motion_t motion;
  int failures, tests_run, stop_n, n;
  logic [8:0] lc [4] = '{9'h140, 9'h040, 9'h000, 9'h0c0};
  bit tp [4] = '{1, 0, 1, 0};
  bit es [4] = '{1, 1, 0, 1};
  bit ei [4] = '{1, 0, 0, 1};
  aol_supervisor #(.GUARD_CYC(G), .TICK_CYC(TICK), .LOSS_CYC(LOSS))
  i_aol_supervisor (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .motion(motion),
    .start_req(start_req), .manual_req(manual_req), .step_in(step_in),
    .dir_in(dir_in), .scan_done(scan_done), .link_formed(link_formed),
    .encoder_up_down_pin(enc_pin), .start_grant(start_grant),
    .start_error(start_error), .manual_grant(manual_grant),
    .stop_req(stop_req), .stop_immediate(stop_immediate),
    .step_out(step_out), .dir_out(dir_out), .count_up(count_up),
    .general_out(general_out), .peer_link_lost(peer_link_lost));
  aol_link_peer i_aol_link_peer (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .link_up(link_up), .scan_done(scan_done), .link_formed(link_formed));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (tog) step_in <= ~step_in;
    if (stop_req === 1'b1) begin
      stop_n++;
      imm_q = stop_immediate;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction
  function automatic logic [3:0] pins(input logic [8:0] k, logic [3:0] d);
    return d ^ {k[3], {3{k[2]}}};
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(string nm);
    failures++;
    $display("[ERR] %s expected done seen timeout", nm);
    wrap_up;
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  // ready and read data are taken as sampled at the rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      if (++k > 50) hang("hready");
      @(posedge sys_clk);
    end
    rd = hrdata;
  endtask
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic pulse(bit man);
    @(posedge sys_clk);
    if (man) manual_req <= 1'b1;
    else start_req <= 1'b1;
    @(posedge sys_clk);
    manual_req <= 1'b0;
    start_req <= 1'b0;
    #1;
  endtask
  task automatic wait_pin(input bit lost, input logic v);
    n = 0;
    while ((lost ? peer_link_lost : general_out[3]) !== v) begin
      cyc(1);
      if (++n > 200) hang("pin wait");
    end
  endtask
  initial begin
    {hsel, hwrite, start_req, manual_req, step_in, dir_in, enc_pin} = '0;
    {haddr, hwdata, htrans, motion, tog, imm_q} = '0;
    {failures, tests_run, stop_n} = '0;
    sys_rst = 1'b1;
    link_up = 1'b1;
    seed = 32'h533e_33ea;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    ahb(0, aol_pkg::ADDR_CTRL, 0);
    chk("ctrl", 32'h0000_0040, rd);
    chk("resp", 0, hresp);
    ahb(0, aol_pkg::ADDR_WDOG, 0);
    chk("wdog", 32'h0000_0000, rd);
    chk("pins", 32'h0000_0000, {28'h000_0000, general_out});
    ahb(0, 8'h10, 0);
    chk("unmapped", 32'h0000_0000, rd);
    ahb(1, aol_pkg::ADDR_WDOG, 32'h0000_01ff);
    ahb(0, aol_pkg::ADDR_WDOG, 0);
    chk("wdog max", 32'h0000_00ff, rd);
    ahb(1, aol_pkg::ADDR_WDOG, 0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      c = {3'b001, seed[5:2], 2'b00};
      ahb(1, aol_pkg::ADDR_CTRL, {23'h00_0000, c});
      ahb(1, aol_pkg::ADDR_OUTS, {28'h000_0000, seed[11:8]});
      dir_in <= seed[12];
      enc_pin <= seed[13];
      cyc(6);
      chk("gout", pins(c, seed[11:8]), general_out);
      chk("dir", seed[12] ^ c[4], dir_out);
      chk("count", seed[13] ^ c[5], count_up);
    end
    ahb(1, aol_pkg::ADDR_CTRL, 32'h0000_0041);
    ahb(1, aol_pkg::ADDR_OUTS, 32'h0000_0004);
    cyc(2);
    chk("ind off data", 0, general_out[2]);
    tog = 1'b1;
    for (int m = 1; m >= 0; m--) begin
      @(posedge sys_clk);
      motion.axis_moving <= m[0];
      cyc(G);
      chk("ind early", !m[0], general_out[2]);
      cyc(G + 6);
      chk("ind", m[0], general_out[2]);
    end
    tog = 1'b0;
    ahb(1, aol_pkg::ADDR_OUTS, 0);
    chk("step follow", step_in, step_out);
    ahb(1, aol_pkg::ADDR_CTRL, 32'h0000_0040);
    ahb(1, aol_pkg::ADDR_WDOG, 32'h0000_0002);
    cyc(2);
    chk("wd set", 1, general_out[3]);
    motion.axis_moving <= 1'b1;
    ahb(1, aol_pkg::ADDR_OUTS, 0);
    ahb(0, aol_pkg::ADDR_OUTS, 0);
    chk("wd protect", 1, rd[3]);
    motion.axis_moving <= 1'b0;
    cyc(TICK - 3);
    motion.axis_moving <= 1'b1;
    cyc(3);
    motion.axis_moving <= 1'b0;
    cyc(TICK - 3);
    chk("wd restart", 1, general_out[3]);
    wait_pin(0, 1'b0);
    chk("wd expire", 1, n <= TICK + 5);
    ahb(1, aol_pkg::ADDR_WDOG, 32'h0000_0003);
    ahb(1, aol_pkg::ADDR_OUTS, 0);
    cyc(2);
    chk("wd stop write", 0, general_out[3]);
    ahb(1, aol_pkg::ADDR_WDOG, 0);
    ahb(1, aol_pkg::ADDR_CTRL, 32'h0000_0042);
    pulse(0);
    chk("start low", 2'b01, {start_grant, start_error});
    ahb(0, aol_pkg::ADDR_STATUS, 0);
    chk("refused flag", 1, rd[aol_pkg::ST_START_REFUSED]);
    ahb(1, aol_pkg::ADDR_OUTS, 32'h0000_0008);
    pulse(0);
    chk("start high", 2'b10, {start_grant, start_error});
    for (int i = 0; i < 4; i++) begin
      ahb(1, aol_pkg::ADDR_CTRL, {23'h00_0000, lc[i]});
      ahb(1, aol_pkg::ADDR_OUTS, 32'h0000_0007);
      motion <= {1'b1, tp[i], 2'b00};
      cyc(20);
      stop_n = 0;
      link_up <= 1'b0;
      wait_pin(1, 1'b1);
      chk("loss time", 1, n >= LOSS);
      cyc(2);
      chk("stop", es[i], stop_n);
      if (es[i]) chk("stop kind", ei[i], imm_q);
      ahb(0, aol_pkg::ADDR_OUTS, 0);
      chk("clear", lc[i][8] ? 3'h0 : 3'h7, rd[2:0]);
      pulse(1);
      chk("manual lost", 0, manual_grant);
      link_up <= 1'b1;
      wait_pin(1, 1'b0);
      chk("regain", 1, n >= 8);
      motion <= '0;
      cyc(20);
    end
    pulse(1);
    chk("manual ok", 1, manual_grant);
    wrap_up;
  end
endmodule
